/* core/cache_snoop_hold_writeback.sv */
// snoop responder of the on-chip cache under hold/acknowledge arbitration
// assumes all pins synchronous to i_ref_clk; two-way address pin split in/out/oe
//
// Functional notes
// RULE_01 - snoop strobe only after acknowledge high one clock
// RULE_02 - acknowledge no sooner than one clock after request
// RULE_03 - invalidate qualifier: 0 read, 1 write
// RULE_04 - hit result exactly two clocks after strobe
// RULE_05 - miss drives hit indication high
// RULE_06 - unmodified hit drives hit indication high
// RULE_07 - modified hit drives hit indication low
// RULE_08 - write-back is four words from offset zero
// RULE_09 - no write-back while hold request asserted
// RULE_10 - ignore snoop strobes until write-back completes
// RULE_11 - outside drops hold, backs off master after hit
// RULE_12 - outside may reassert hold after write-back strobe
// RULE_13 - start: strobe 0, cacheable 0, write 1
// RULE_14 - first strobe one clock after hold release
// RULE_15 - done when last and ready both low
// RULE_16 - hit indication high clock after final transfer
// RULE_17 - no pending: acknowledge one clock after request
// RULE_18 - write-back goes before pending processor accesses
// RULE_19 - pending: acknowledge one clock after it completes
// RULE_20 - outside releases master, retry starts new snoop
// RULE_21 - line ends shared or invalid per qualifier
// RULE_22 - outside keeps hold one clock after hit
// RULE_23 - qualifier sampled with the snoop strobe
// RULE_24 - address bus floats while acknowledge asserted
`timescale 1ns/1ns
`include "snoop_cfg.svh"
module cache_snoop_hold_writeback #(
  parameter int NUM_LINES = `SNP_LINES,
  parameter int BUF_DEPTH = `SNP_BUF_DEPTH
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_ce,
  input  wire logic                     i_hold_req,
  output logic                          o_bus_hold_acknowledge,
  input  wire logic                     i_snoop_address_strobe_n,
  input  wire logic                     i_snoop_invalidate_qualifier,
  output logic                          o_modified_hit_indication_n,
  input  wire logic [`SNP_ADDR_W-1:0]   i_addr,
  output logic      [`SNP_ADDR_W-1:0]   o_addr,
  output logic                          o_addr_oe_n,
  output logic                          o_address_strobe_n,
  output logic                          o_cache_n,
  output logic                          o_write_read,
  output logic                          o_burst_last_transfer_n,
  input  wire logic                     i_burst_ready_input_n,
  output logic      [`SNP_DATA_W-1:0]   o_data,
  output logic                          o_data_oe_n,
  input  wire logic                     i_pend_req,
  input  wire logic                     i_pend_done,
  output logic                          o_pend_stall,
  input  wire snoop_pkg::fill_type      i_fill
);
  import snoop_pkg::*;

  // index and pointer widths, one bit at the least
  localparam int IDX_W = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int TAG_W = `SNP_ADDR_W - `SNP_OFF_W;

  // refuse sizes the index and pointer arithmetic cannot serve
  if (NUM_LINES < 2 || NUM_LINES > (1 << `SNP_IDX_MAX) ||
      (NUM_LINES & (NUM_LINES - 1)) != 0) begin : g_bad_lines
    $error("NUM_LINES must be a power of two within the index field");
  end
  // the buffer pointers wrap by overflow, which needs a power-of-two depth; only two entries are allowed
  if (BUF_DEPTH != 2) begin : g_bad_depth
    $error("BUF_DEPTH must be 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  snp_state_type            state_r, state_nxt;
  logic                     bus_hold_acknowledge_r, bus_hold_acknowledge_nxt;
  logic                     modified_hit_indication_r, modified_hit_indication_nxt;
  logic                     inv_r, inv_nxt;
  logic [TAG_W-1:0]         line_addr_r, line_addr_nxt;
  logic [2:0]               wr_cnt_r, wr_cnt_nxt;
  logic [2:0]               rd_cnt_r, rd_cnt_nxt;
  logic [TAG_W-1:0]         tag_r   [NUM_LINES];
  logic [TAG_W-1:0]         tag_nxt [NUM_LINES];
  mesi_type                 st_r    [NUM_LINES];
  mesi_type                 st_nxt  [NUM_LINES];
  logic [`SNP_DATA_W-1:0]   dat_r   [NUM_LINES][`SNP_BEATS];
  logic [`SNP_DATA_W-1:0]   dat_nxt [NUM_LINES][`SNP_BEATS];
  logic [`SNP_DATA_W-1:0]   buf_r   [BUF_DEPTH];
  logic [`SNP_DATA_W-1:0]   buf_nxt [BUF_DEPTH];
  logic [PTR_W-1:0]         wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PTR_W:0]           cnt_r, cnt_nxt;

  // combinational helpers of the lookup and the buffer
  logic [IDX_W-1:0]         look_idx;
  logic                     look_hit;
  logic                     buf_full, buf_empty;
  logic                     push, pop;
  logic                     last_beat;
  logic                     burst_done;

  //////////////////////////////////////////////////////////////////////////////
  // lookup of the latched snoop line against the tag store
  // direct mapped: the low line bits pick the entry
  always_comb begin
    look_idx = line_addr_r[IDX_W-1:0];
    look_hit = (st_r[look_idx] != LINE_INV) && (tag_r[look_idx] == line_addr_r);
  end

  // two-entry buffer between line store and data pins; stalls on ready high
  always_comb begin
    buf_full   = (cnt_r == (PTR_W+1)'(BUF_DEPTH));
    buf_empty  = (cnt_r == '0);
    push       = ((state_r == ST_ADS) || (state_r == ST_BURST)) &&
                 (wr_cnt_r != `SNP_BEAT_END) && !buf_full;
    pop        = (state_r == ST_BURST) && !buf_empty && !i_burst_ready_input_n;
    last_beat  = (rd_cnt_r == `SNP_LAST_BEAT);
    burst_done = pop && last_beat;                                    // [RULE_15]
  end

  // pointers wrap on their own width; push stops while the buffer is full
  always_comb begin
    buf_nxt = buf_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      buf_nxt[wp_nxt] = dat_r[look_idx][wr_cnt_r[1:0]];               // [RULE_08]
      wp_nxt = wp_r + 1'b1;
    end
    if (pop)
      rp_nxt = rp_r + 1'b1;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: acknowledge, snoop result, write-back, pending hand-off
  // hold raised again during the burst only takes effect in done
  always_comb begin
    state_nxt     = state_r;
    bus_hold_acknowledge_nxt      = bus_hold_acknowledge_r;
    modified_hit_indication_nxt      = modified_hit_indication_r;
    inv_nxt       = inv_r;
    line_addr_nxt = line_addr_r;
    wr_cnt_nxt    = push ? wr_cnt_r + 3'h1 : wr_cnt_r;
    rd_cnt_nxt    = pop ? rd_cnt_r + 3'h1 : rd_cnt_r;
    tag_nxt       = tag_r;
    st_nxt        = st_r;
    dat_nxt       = dat_r;
    // processor-side line load; a snoop update below overrides it
    if (i_fill.valid) begin
      tag_nxt[i_fill.index[IDX_W-1:0]] = i_fill.tag;
      st_nxt[i_fill.index[IDX_W-1:0]]  = i_fill.state;
      for (int b = 0; b < `SNP_BEATS; b++)
        dat_nxt[i_fill.index[IDX_W-1:0]][b] = i_fill.data[b];
    end
    case (state_r)
      ST_IDLE: begin
        // registered grant: earliest one clock after the request
        if (i_hold_req && !i_pend_req) begin
          bus_hold_acknowledge_nxt  = 1'b1;                                           // [RULE_02]
          state_nxt = ST_BUS_HOLD_ACKNOWLEDGE;
        end
      end
      ST_BUS_HOLD_ACKNOWLEDGE: begin
        // a strobe after hold has dropped is not a snoop
        if (!i_hold_req) begin
          bus_hold_acknowledge_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end else if (!i_snoop_address_strobe_n) begin
          inv_nxt       = i_snoop_invalidate_qualifier;               // [RULE_23]
          line_addr_nxt = i_addr[`SNP_ADDR_W-1:`SNP_OFF_W];
          state_nxt     = ST_LOOK;
        end
      end
      ST_LOOK: begin
        // result registered here shows two clocks after the strobe
        if (look_hit && st_r[look_idx] == LINE_MOD) begin
          modified_hit_indication_nxt   = 1'b0;                                          // [RULE_04] [RULE_07]
          wr_cnt_nxt = 3'h0;
          rd_cnt_nxt = 3'h0;
          state_nxt  = ST_WAIT;
        end else begin
          modified_hit_indication_nxt = 1'b1;                                            // [RULE_05] [RULE_06]
          if (look_hit)
            st_nxt[look_idx] = inv_r ? LINE_INV : LINE_SHR;
          if (i_hold_req) begin
            state_nxt = ST_BUS_HOLD_ACKNOWLEDGE;
          end else begin
            bus_hold_acknowledge_nxt  = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        // strobes ignored here; write-back waits for hold to drop
        // the outside keeps hold one clock past the hit, never less
        if (!i_hold_req) begin                                        // [RULE_09] [RULE_10]
          bus_hold_acknowledge_nxt  = 1'b0;
          state_nxt = ST_ADS;                                         // [RULE_14]
        end
      end
      ST_ADS: begin
        // one clock of address strobe, first word loads meanwhile
        state_nxt = ST_BURST;                                         // [RULE_13]
      end
      ST_BURST: begin
        // hold is not looked at until the final transfer
        if (burst_done) begin
          modified_hit_indication_nxt         = 1'b1;                                    // [RULE_16]
          st_nxt[look_idx] = inv_r ? LINE_INV : LINE_SHR;             // [RULE_21]
          state_nxt        = ST_DONE;
        end
      end
      ST_DONE: begin
        // pending processor access goes first; grant waits for it
        if (i_pend_req) begin
          state_nxt = ST_PEND;                                        // [RULE_18]
        end else if (i_hold_req) begin
          bus_hold_acknowledge_nxt  = 1'b1;                                           // [RULE_17]
          state_nxt = ST_BUS_HOLD_ACKNOWLEDGE;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PEND: begin
        // grant comes from idle, one clock after completion at the soonest
        if (i_pend_done)
          state_nxt = ST_IDLE;                                        // [RULE_19]
      end
      default: begin
        // stray encodings return to the reset picture
        state_nxt = ST_IDLE;
        bus_hold_acknowledge_nxt  = `SNP_BUS_HOLD_ACKNOWLEDGE_RST;
        modified_hit_indication_nxt  = `SNP_MODIFIED_HIT_INDICATION_RST;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; clock enable freezes everything
  // resetting the line store costs area but leaves no unknown tags
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= ST_IDLE;
      bus_hold_acknowledge_r      <= `SNP_BUS_HOLD_ACKNOWLEDGE_RST;
      modified_hit_indication_r      <= `SNP_MODIFIED_HIT_INDICATION_RST;
      inv_r       <= 1'b0;
      line_addr_r <= '0;
      wr_cnt_r    <= 3'h0;
      rd_cnt_r    <= 3'h0;
      wp_r        <= '0;
      rp_r        <= '0;
      cnt_r       <= '0;
      for (int i = 0; i < BUF_DEPTH; i++)
        buf_r[i] <= '0;
      // every line starts invalid, so early snoops all miss
      for (int l = 0; l < NUM_LINES; l++) begin
        tag_r[l] <= '0;
        st_r[l]  <= LINE_INV;
        for (int b = 0; b < `SNP_BEATS; b++)
          dat_r[l][b] <= '0;
      end
    end else if (i_ce) begin
      state_r     <= state_nxt;
      bus_hold_acknowledge_r      <= bus_hold_acknowledge_nxt;
      modified_hit_indication_r      <= modified_hit_indication_nxt;
      inv_r       <= inv_nxt;
      line_addr_r <= line_addr_nxt;
      wr_cnt_r    <= wr_cnt_nxt;
      rd_cnt_r    <= rd_cnt_nxt;
      wp_r        <= wp_nxt;
      rp_r        <= rp_nxt;
      cnt_r       <= cnt_nxt;
      buf_r       <= buf_nxt;
      tag_r       <= tag_nxt;
      st_r        <= st_nxt;
      dat_r       <= dat_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins; bus driven only during the write-back, floated otherwise
  always_comb begin
    o_bus_hold_acknowledge      = bus_hold_acknowledge_r;
    o_modified_hit_indication_n = modified_hit_indication_r;
    // write-back address always starts at word offset zero
    o_addr                      = {line_addr_r, `SNP_OFF_W'(0)};       // [RULE_08]
    o_addr_oe_n                 = !((state_r == ST_ADS) ||
                                    (state_r == ST_BURST));           // [RULE_24]
    // control strobes decode straight from the state register; the last-transfer flag also takes the beat count
    o_address_strobe_n          = (state_r != ST_ADS);                // [RULE_13]
    o_cache_n                   = (state_r != ST_ADS);
    o_write_read                = !o_addr_oe_n;
    o_burst_last_transfer_n     = !((state_r == ST_BURST) && last_beat);
    o_data                      = buf_r[rp_r];
    o_data_oe_n                 = (state_r != ST_BURST);
    o_pend_stall                = !((state_r == ST_IDLE) ||
                                    (state_r == ST_PEND));            // [RULE_18]
  end
endmodule : cache_snoop_hold_writeback

/* inc/snoop_cfg.svh */
// constants for the snoop responder: widths, counts and reset values
// assumes inclusion by bare name from the package and the core
`ifndef SNOOP_CFG_SVH
`define SNOOP_CFG_SVH
`define SNP_ADDR_W      32
`define SNP_DATA_W      32
`define SNP_OFF_W       4
`define SNP_BEATS       4
`define SNP_BEAT_END    3'h4
`define SNP_LAST_BEAT   3'h3
`define SNP_LINES       8
`define SNP_IDX_MAX     8
`define SNP_BUF_DEPTH   2
`define SNP_MODIFIED_HIT_INDICATION_RST    1'h1
`define SNP_BUS_HOLD_ACKNOWLEDGE_RST    1'h0
`endif

/* inc/snoop_pkg.sv */
// types shared by the snoop responder and its bench
// assumes snoop_cfg.svh is on the include path
`include "snoop_cfg.svh"
package snoop_pkg;
  // line coherency state
  typedef enum logic [1:0] {
    LINE_INV = 2'h0,
    LINE_SHR = 2'h1,
    LINE_EXC = 2'h2,
    LINE_MOD = 2'h3
  } mesi_type;

  // responder sequencer, gray along the write-back path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_BUS_HOLD_ACKNOWLEDGE  = 3'h1,
    ST_LOOK  = 3'h3,
    ST_WAIT  = 3'h2,
    ST_ADS   = 3'h6,
    ST_BURST = 3'h7,
    ST_DONE  = 3'h5,
    ST_PEND  = 3'h4
  } snp_state_type;

  // line load from the processor side
  typedef struct packed {
    logic                                    valid;
    logic [`SNP_IDX_MAX-1:0]                 index;
    logic [`SNP_ADDR_W-`SNP_OFF_W-1:0]       tag;
    mesi_type                                state;
    logic [`SNP_BEATS-1:0][`SNP_DATA_W-1:0]  data;
  } fill_type;
endpackage : snoop_pkg

/* testbench/burst_target.sv */
// memory side that accepts the write-back burst with set wait states
// assumes responder pins settle before the rising edge; ready pulled up
`timescale 1ns/1ns
module burst_target (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_address_strobe_n,
  input  wire logic        i_data_oe_n,
  input  wire logic        i_burst_last_transfer_n,
  input  wire logic [31:0] i_data,
  input  wire logic [1:0]  i_wait,
  output logic             o_burst_ready_input_n
);
  logic [31:0] words [4];
  int          n_words;
  int          wait_cnt;
  logic        busy;
  // a word is taken at each edge with ready low; ready idles high
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_burst_ready_input_n <= 1'b1;
      n_words = 0;
      busy = 1'b0;
    end else begin
      if (!o_burst_ready_input_n && !i_data_oe_n) begin
        words[n_words % 4] = i_data;
        n_words++;
      end
      if (!o_burst_ready_input_n && !i_burst_last_transfer_n) busy = 1'b0;
      if (!i_address_strobe_n) begin
        busy = 1'b1;
        wait_cnt = 0;
      end
      if (busy && wait_cnt >= i_wait) begin
        o_burst_ready_input_n <= #2 1'b0;
        wait_cnt = 0;
      end else begin
        o_burst_ready_input_n <= #2 1'b1;
        wait_cnt++;
      end
    end
  end
endmodule : burst_target

/* testbench/snoop_asserts.sv */
// pin-level checks for the snoop responder
// assumes binding to cache_snoop_hold_writeback, one clock domain
`timescale 1ns/1ns
module snoop_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_hold_req,
  input wire logic        o_bus_hold_acknowledge,
  input wire logic        i_snoop_address_strobe_n,
  input wire logic        o_modified_hit_indication_n,
  input wire logic [31:0] o_addr,
  input wire logic        o_addr_oe_n,
  input wire logic        o_address_strobe_n,
  input wire logic        o_cache_n,
  input wire logic        o_write_read,
  input wire logic        o_burst_last_transfer_n,
  input wire logic        i_burst_ready_input_n,
  input wire logic        o_data_oe_n,
  input wire logic        i_pend_done,
  input wire logic        o_pend_stall
);
  logic [2:0] beat_r;
  logic [2:0] beat_nxt;
  // accepted beats, restarted by each write-back strobe
  always_comb begin
    beat_nxt = beat_r;
    if (!o_address_strobe_n) beat_nxt = 3'h0;
    else if (!o_data_oe_n && !i_burst_ready_input_n) beat_nxt = beat_r + 3'h1;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) beat_r <= 3'h0;
    else beat_r <= beat_nxt;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_ack_after_req:
    assert property ($rose(o_bus_hold_acknowledge) |-> $past(i_hold_req))
    else $error("ack rose without request");
  a_hit_two_clk:
    assert property ($fell(o_modified_hit_indication_n) |-> !$past(i_snoop_address_strobe_n, 2))
    else $error("hit not two clocks after strobe");
  a_wb_after_release:
    assert property (!o_address_strobe_n |-> !$past(i_hold_req) && !o_bus_hold_acknowledge)
    else $error("write-back under hold");
  a_wb_start_pins:
    assert property (!o_address_strobe_n |-> !o_cache_n && o_write_read && !o_addr_oe_n
                     && o_addr[3:0] == 4'h0 && o_pend_stall)
    else $error("bad write-back start pins");
  a_last_on_fourth:
    assert property (!o_data_oe_n && !i_burst_ready_input_n
                     |-> o_burst_last_transfer_n == (beat_r != 3'h3))
    else $error("last flag not on fourth word");
  a_hit_release:
    assert property (!o_burst_last_transfer_n && !i_burst_ready_input_n
                     |=> o_modified_hit_indication_n)
    else $error("hit not released after burst");
  a_hit_holds:
    assert property ($rose(o_modified_hit_indication_n)
                     |-> !$past(o_burst_last_transfer_n) && !$past(i_burst_ready_input_n))
    else $error("hit released before burst end");
  a_float_in_ack:
    assert property (o_bus_hold_acknowledge |-> o_addr_oe_n && o_data_oe_n)
    else $error("driving bus while acknowledged");
  a_ack_after_pend:
    assert property (i_pend_done |=> !o_bus_hold_acknowledge)
    else $error("ack too soon after pending access");
endmodule : snoop_asserts

/* testbench/test_cache_snoop_hold_writeback.sv */
// bench: snoop miss, clean hits, write-backs with and without pending access
// assumes snoop_pkg, snoop_asserts and burst_target compiled before it
`timescale 1ns/1ns
module test_cache_snoop_hold_writeback;
  import snoop_pkg::*;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_hold_req = 1'b0;
  logic i_snoop_address_strobe_n = 1'b1, i_snoop_invalidate_qualifier = 1'b0;
  logic i_pend_req = 1'b0, i_pend_done = 1'b0, i_burst_ready_input_n;
  logic [31:0] i_addr = 32'h0, o_addr, o_data;
  logic o_bus_hold_acknowledge, o_modified_hit_indication_n, o_addr_oe_n;
  logic o_address_strobe_n, o_cache_n, o_write_read, o_burst_last_transfer_n;
  logic o_data_oe_n, o_pend_stall;
  logic [1:0]  wt = 2'h0;
  fill_type    i_fill = '0;
  int          n_fail = 0, tests_run = 0, cycles = 0;
  cache_snoop_hold_writeback dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_hold_req(i_hold_req),
    .o_bus_hold_acknowledge(o_bus_hold_acknowledge),
    .i_snoop_address_strobe_n(i_snoop_address_strobe_n),
    .i_snoop_invalidate_qualifier(i_snoop_invalidate_qualifier),
    .o_modified_hit_indication_n(o_modified_hit_indication_n),
    .i_addr(i_addr), .o_addr(o_addr), .o_addr_oe_n(o_addr_oe_n),
    .o_address_strobe_n(o_address_strobe_n), .o_cache_n(o_cache_n),
    .o_write_read(o_write_read), .o_burst_last_transfer_n(o_burst_last_transfer_n),
    .i_burst_ready_input_n(i_burst_ready_input_n), .o_data(o_data),
    .o_data_oe_n(o_data_oe_n), .i_pend_req(i_pend_req), .i_pend_done(i_pend_done),
    .o_pend_stall(o_pend_stall), .i_fill(i_fill));
  burst_target tgt (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_address_strobe_n(o_address_strobe_n), .i_data_oe_n(o_data_oe_n),
    .i_burst_last_transfer_n(o_burst_last_transfer_n), .i_data(o_data),
    .i_wait(wt), .o_burst_ready_input_n(i_burst_ready_input_n));
  always #10 i_ref_clk = ~i_ref_clk;
  // hang guard, far above the fewer than one hundred cycles the tests need
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // one-cycle line load; word w of the line reads as its address plus w
  task automatic load(input logic [31:0] a, input mesi_type st);
    i_fill = '{1'b1, {5'h0, a[6:4]}, a[31:4], st, {a | 32'h3, a | 32'h2, a | 32'h1, a}};
    tick();
    i_fill.valid = 1'b0;
  endtask : load
  task automatic grant();
    i_hold_req = 1'b1;
    tick(2);
    chk(o_bus_hold_acknowledge, 1'b1);
    chk(o_addr_oe_n, 1'b1);
  endtask : grant
  // strobe in c0, result looked at in c2
  task automatic snoop(input logic [31:0] a, input logic q, input logic exp);
    i_addr = a;
    i_snoop_invalidate_qualifier = q;
    i_snoop_address_strobe_n = 1'b0;
    tick();
    i_snoop_address_strobe_n = 1'b1;
    i_addr = ~a;
    tick();
    chk(o_modified_hit_indication_n, exp);
  endtask : snoop
  // entered in c2 of a modified hit; ends one cycle after the hit clears
  task automatic writeback(input logic [31:0] a, input logic [1:0] w, input logic pend);
    int k;
    wt = w;
    i_pend_req = pend;
    tick();
    i_hold_req = 1'b0;
    for (k = 0; k < 20 && o_address_strobe_n; k++) tick();
    chk(o_addr, {a[31:4], 4'h0});
    chk({o_cache_n, o_write_read, o_bus_hold_acknowledge, o_pend_stall}, 4'h5);
    if (pend) i_snoop_address_strobe_n = 1'b0;
    tick();
    i_snoop_address_strobe_n = 1'b1;
    i_hold_req = 1'b1;
    for (k = 0; k < 40 && !o_modified_hit_indication_n; k++) tick();
    for (k = 0; k < 4; k++) chk(tgt.words[k], a | 32'(k));
    tick();
    chk(o_bus_hold_acknowledge, !pend);
    chk(o_modified_hit_indication_n, 1'b1);
  endtask : writeback
  ////////////////////////////////////////////////////////////////////////
  task automatic test_miss();
    grant();
    snoop(32'h0000_1230, 1'b0, 1'b1);
    snoop(32'h0000_1230, 1'b1, 1'b1);
    $display("miss test done");
  endtask : test_miss
  task automatic test_clean();
    load(32'h0000_2040, LINE_EXC);
    snoop(32'h0000_2040, 1'b0, 1'b1);
    load(32'h0000_2050, LINE_SHR);
    snoop(32'h0000_2050, 1'b1, 1'b1);
    $display("clean hit test done");
  endtask : test_clean
  task automatic test_wb_read();
    load(32'h0000_4060, LINE_MOD);
    snoop(32'h0000_4060, 1'b0, 1'b0);
    writeback(32'h0000_4060, 2'h0, 1'b0);
    tick();
    snoop(32'h0000_4060, 1'b0, 1'b1);
    $display("write-back test done");
  endtask : test_wb_read
  // stalled burst, stray strobe to another dirty line, pending access after
  task automatic test_wb_pend();
    int k;
    load(32'h0000_5070, LINE_MOD);
    load(32'h0000_6000, LINE_MOD);
    tick();
    snoop(32'h0000_5070, 1'b1, 1'b0);
    i_addr = 32'h0000_6000;
    writeback(32'h0000_5070, 2'h2, 1'b1);
    chk(o_pend_stall, 1'b0);
    i_pend_req = 1'b0;
    i_pend_done = 1'b1;
    tick();
    i_pend_done = 1'b0;
    chk(o_bus_hold_acknowledge, 1'b0);
    for (k = 0; k < 4 && !o_bus_hold_acknowledge; k++) tick();
    chk(o_bus_hold_acknowledge, 1'b1);
    $display("pending write-back test done");
  endtask : test_wb_pend
  // clock enable low holds off the grant although hold is requested
  task automatic test_freeze();
    i_hold_req = 1'b0;
    tick();
    i_ce = 1'b0;
    i_hold_req = 1'b1;
    tick(3);
    chk(o_bus_hold_acknowledge, 1'b0);
    i_ce = 1'b1;
    tick();
    chk(o_bus_hold_acknowledge, 1'b1);
    $display("clock enable test done");
  endtask : test_freeze
  initial begin
    tick(3);
    i_rst_n = 1'b1;
    test_miss();
    test_clean();
    test_wb_read();
    test_wb_pend();
    test_freeze();
    final_report();
  end
endmodule : test_cache_snoop_hold_writeback
bind cache_snoop_hold_writeback snoop_asserts chk_i (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hold_req(i_hold_req),
  .o_bus_hold_acknowledge(o_bus_hold_acknowledge),
  .i_snoop_address_strobe_n(i_snoop_address_strobe_n),
  .o_modified_hit_indication_n(o_modified_hit_indication_n),
  .o_addr(o_addr), .o_addr_oe_n(o_addr_oe_n), .o_address_strobe_n(o_address_strobe_n),
  .o_cache_n(o_cache_n), .o_write_read(o_write_read),
  .o_burst_last_transfer_n(o_burst_last_transfer_n),
  .i_burst_ready_input_n(i_burst_ready_input_n), .o_data_oe_n(o_data_oe_n),
  .i_pend_done(i_pend_done), .o_pend_stall(o_pend_stall));
